// [logic/sps_link.sv]
// Serial shift engine running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module sps_link
    import sps_pkg::*;
(
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic resetn,
    input wire logic mosi,
    input wire logic [WORD_W-1:0] tx_word,
    output logic [WORD_W-1:0] rx_word,
    output logic [CNT_W-1:0] pulse_cnt,
    output logic frame_tog,
    output logic miso,
    output logic miso_oe_n
);
    logic idle;
    logic start_r;
    logic so_r;
    logic [CNT_W-1:0] cnt_inc;
    logic [3:0] tx_idx;
    logic so_nxt;

    // The clock stops between frames, so frame start is armed by select itself
    assign idle = chip_select_n | ~resetn;
    assign cnt_inc = (pulse_cnt == CNT_SAT) ? CNT_SAT : pulse_cnt + CNT_ONE;
    assign tx_idx = 4'(WORD_W - 1 - int'(pulse_cnt));
    assign so_nxt = (pulse_cnt >= FRAME_BITS) ? 1'b0 : tx_word[tx_idx];

    always_ff @(posedge sclk or posedge idle) begin
        if (idle) begin
            start_r <= 1'b1;
        end else begin
            start_r <= 1'b0;
        end
    end

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            rx_word <= STATUS_RST;
            pulse_cnt <= '0;
            frame_tog <= 1'b0;
        end else if (!chip_select_n) begin
            rx_word <= {rx_word[WORD_W-2:0], mosi};
            if (start_r) begin
                pulse_cnt <= CNT_ONE;
                frame_tog <= ~frame_tog;
            end else begin
                pulse_cnt <= cnt_inc;
            end
        end
    end

    always_ff @(negedge sclk or negedge resetn) begin
        if (!resetn) begin
            so_r <= 1'b0;
        end else if (!chip_select_n) begin
            so_r <= so_nxt;
        end
    end

    // Cleared by select itself, so the last bit of the previous frame never
    // shows between the first rising and the first falling clock edge
    logic shifted_r;

    always_ff @(negedge sclk or posedge idle) begin
        if (idle) begin
            shifted_r <= 1'b0;
        end else begin
            shifted_r <= 1'b1;
        end
    end

    // Most significant bit is presented from select fall until the first fall
    assign miso = shifted_r ? so_r : tx_word[WORD_W-1];
    assign miso_oe_n = chip_select_n;
endmodule
`default_nettype wire

// [logic/sps_pkg.sv]
// Constants and types shared by the serial slave and the power sequencer
package sps_pkg;
    // Core clock rate
    localparam int CLK_MHZ = 250;
    // Serial frame
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
    localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    // Power-on delay and undervoltage filter
    localparam int T_POR_US = 10;
    localparam int T_UV_NS = 2000;
    localparam int TMR_W = 12;
    localparam logic [TMR_W-1:0] POR_CYC = TMR_W'(T_POR_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] UV_CYC = TMR_W'((T_UV_NS * CLK_MHZ + 999) / 1000);
    // Command word: address in the top nibble, data below
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 12;
    localparam int DATA_W = 12;
    localparam logic [3:0] ADDR_NOP = 4'h0;
    localparam logic [3:0] ADDR_CTL = 4'h1;
    localparam logic [3:0] ADDR_CFG = 4'h2;
    // Control register fields
    localparam int CTL_HOLD = 0;
    localparam int CTL_SENSOR = 1;
    localparam int CTL_RELAY1 = 2;
    localparam int CTL_RELAY2 = 3;
    localparam int CTL_HSON = 4;
    localparam logic [DATA_W-1:0] CTL_RST = 12'h000;
    // Configuration register fields
    localparam int CFG_HSD = 0;
    localparam int CFG_SDD = 1;
    localparam int CFG_DUTY_LO = 2;
    localparam int DUTY_W = 7;
    localparam logic [DATA_W-1:0] CFG_RST = 12'h000;
    // Status word fields
    localparam int ST_ERR = 15;
    localparam int ST_KEY = 14;
    localparam int ST_KSO = 13;
    localparam int ST_UV = 12;
    localparam int ST_HOLD = 11;
    localparam int FAULT_W = 4;
    localparam logic [WORD_W-1:0] STATUS_RST = 16'h0000;

    typedef struct packed {
        logic key_switch_in;
        logic vcc_por_ok;
        logic vcc_uv_low;
        logic relay1_input;
        logic relay2_input;
        logic [FAULT_W-1:0] fault;
    } sps_pins_t;

    localparam sps_pins_t PINS_RST = '0;

    typedef enum logic [3:0] {
        S_SLEEP = 4'h1,
        S_POR = 4'h2,
        S_ACTIVE = 4'h4,
        S_HOLD = 4'h8
    } sps_state_t;
endpackage

// [logic/sps_top.sv]
// Serial slave port with supply reset and power sequencing
`timescale 1ns/1ps
`default_nettype none
module sps_top
    import sps_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic chip_select_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire sps_pins_t pins,
    output logic host_reset_n,
    output logic pre_reg_en,
    output logic vcc_reg_en,
    output logic sensor_supply,
    output logic relay1_driver,
    output logic relay2_driver,
    output logic key_state_out,
    output logic [WORD_W-1:0] status_word
);
    function automatic logic cmd_is(input logic [WORD_W-1:0] w, input logic [3:0] a);
        cmd_is = (w[ADDR_HI:ADDR_LO] == a);
    endfunction

    // Link-side results
    logic [WORD_W-1:0] rx_word;
    logic [CNT_W-1:0] pulse_cnt;
    logic frame_tog;
    logic [WORD_W-1:0] snap_r;

    // Synchronisers
    sps_pins_t pins_s1_r;
    sps_pins_t pins_s2_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_seen_r;

    // Sequencer
    sps_state_t state_r;
    sps_state_t state_nxt;
    logic [TMR_W-1:0] por_cnt_r;
    logic [TMR_W-1:0] por_cnt_nxt;
    logic [TMR_W-1:0] uv_cnt_r;
    logic [TMR_W-1:0] uv_cnt_nxt;

    // Registers written over the serial port, plus error flag, fault latches and PWM counter
    logic [DATA_W-1:0] ctl_r;
    logic [DATA_W-1:0] ctl_nxt;
    logic [DATA_W-1:0] cfg_r;
    logic [DATA_W-1:0] cfg_nxt;
    logic spi_err_r;
    logic spi_err_nxt;
    logic [FAULT_W-1:0] fault_r;
    logic [FAULT_W-1:0] fault_nxt;
    logic [DUTY_W-1:0] pwm_cnt_r;

    // Registered outputs
    logic host_reset_n_r;
    logic pre_reg_en_r;
    logic sensor_r;
    logic relay1_r;
    logic relay2_r;
    logic key_state_r;

    sps_link u_link (
        .sclk(spi_sclk),
        .chip_select_n(chip_select_n),
        .resetn(resetn),
        .mosi(spi_mosi),
        .tx_word(snap_r),
        .rx_word(rx_word),
        .pulse_cnt(pulse_cnt),
        .frame_tog(frame_tog),
        .miso(spi_miso),
        .miso_oe_n(spi_miso_oe_n)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins_s1_r <= PINS_RST;
            pins_s2_r <= PINS_RST;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
        end else begin
            pins_s1_r <= pins;
            pins_s2_r <= pins_s1_r;
            cs_s1_r <= chip_select_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            tog_s1_r <= frame_tog;
            tog_s2_r <= tog_s1_r;
        end
    end

    // Frame boundaries seen in the core domain
    logic frame_start;
    logic frame_end;
    logic got_pulses;
    logic bad_len;
    logic cmd_valid;
    logic cmd_ok;
    logic awake;
    logic outputs_on;
    logic hold_bit;
    logic key_in;
    logic uv_trip;
    logic por_done;

    assign frame_start = cs_s3_r & ~cs_s2_r;
    assign frame_end = cs_s2_r & ~cs_s3_r;
    // A frame with no clock pulse never toggles the link flag
    assign got_pulses = tog_s2_r ^ tog_seen_r;
    // Count and shift data are read only after select has settled high,
    // when the serial clock is parked and they cannot move
    assign bad_len = ~got_pulses | (pulse_cnt != FRAME_BITS);
    assign cmd_valid = cmd_is(rx_word, ADDR_NOP) | cmd_is(rx_word, ADDR_CTL)
        | cmd_is(rx_word, ADDR_CFG);
    assign cmd_ok = frame_end & ~bad_len & cmd_valid & awake;

    assign awake = (state_r == S_ACTIVE) | (state_r == S_HOLD);
    assign outputs_on = (state_r == S_ACTIVE);
    assign hold_bit = ctl_r[CTL_HOLD];
    assign key_in = pins_s2_r.key_switch_in;
    assign uv_trip = (uv_cnt_r == UV_CYC);
    assign por_done = (por_cnt_r == POR_CYC);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tog_seen_r <= 1'b0;
        end else if (frame_end) begin
            tog_seen_r <= tog_s2_r;
        end
    end

    // Error flag: a new error wins over the clear taken at status load
    always_comb begin
        spi_err_nxt = spi_err_r;
        if (frame_start) begin
            spi_err_nxt = 1'b0;
        end
        if (frame_end & (bad_len | ~cmd_valid)) begin
            spi_err_nxt = 1'b1;
        end
    end

    // Faults stay reported until the host has seen them in a frame
    genvar gi;
    generate
        for (gi = 0; gi < FAULT_W; gi++) begin : g_fault
            assign fault_nxt[gi] = pins_s2_r.fault[gi] | (fault_r[gi] & ~frame_start);
        end
    endgenerate

    // Command apply on select rise; cleared whenever power-on reset runs
    always_comb begin
        ctl_nxt = ctl_r;
        cfg_nxt = cfg_r;
        if (!awake) begin
            ctl_nxt = CTL_RST;
            cfg_nxt = CFG_RST;
        end else if (cmd_ok & cmd_is(rx_word, ADDR_CTL)) begin
            ctl_nxt = rx_word[DATA_W-1:0];
        end else if (cmd_ok & cmd_is(rx_word, ADDR_CFG)) begin
            cfg_nxt = rx_word[DATA_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spi_err_r <= 1'b0;
            fault_r <= '0;
            ctl_r <= CTL_RST;
            cfg_r <= CFG_RST;
        end else begin
            spi_err_r <= spi_err_nxt;
            fault_r <= fault_nxt;
            ctl_r <= ctl_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    // Status frozen while selected so the link sees a stable word
    logic [WORD_W-1:0] status_now;

    assign status_now = {spi_err_r, key_in, key_state_r, pins_s2_r.vcc_uv_low, hold_bit,
        7'h00, fault_r};

    // Select fall is seen here a few core cycles late; the host lead time
    // covers it, so the frozen word is in place before the first edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            snap_r <= STATUS_RST;
        end else if (cs_s2_r) begin
            snap_r <= status_now;
        end
    end

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_SLEEP: begin
                if (key_in) begin
                    state_nxt = S_POR;
                end
            end
            S_POR: begin
                if (!key_in) begin
                    state_nxt = S_SLEEP;
                end else if (por_done) begin
                    state_nxt = S_ACTIVE;
                end
            end
            S_ACTIVE: begin
                if (uv_trip) begin
                    state_nxt = S_POR;
                end else if (!key_in) begin
                    state_nxt = hold_bit ? S_HOLD : S_SLEEP;
                end
            end
            S_HOLD: begin
                if (uv_trip) begin
                    state_nxt = S_POR;
                end else if (!hold_bit) begin
                    state_nxt = S_SLEEP;
                end else if (key_in) begin
                    state_nxt = S_ACTIVE;
                end
            end
            default: begin
                state_nxt = S_SLEEP;
            end
        endcase
    end

    // Power-on delay restarts whenever the supply drops under threshold
    always_comb begin
        por_cnt_nxt = '0;
        if ((state_r == S_POR) & pins_s2_r.vcc_por_ok) begin
            por_cnt_nxt = por_done ? por_cnt_r : por_cnt_r + 1'b1;
        end
    end

    // Undervoltage must persist for the whole filter time to trip
    always_comb begin
        uv_cnt_nxt = '0;
        if (awake & pins_s2_r.vcc_uv_low) begin
            uv_cnt_nxt = uv_trip ? uv_cnt_r : uv_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= S_SLEEP;
            por_cnt_r <= '0;
            uv_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            por_cnt_r <= por_cnt_nxt;
            uv_cnt_r <= uv_cnt_nxt;
        end
    end

    // Output drive terms
    logic awake_nxt;
    logic pwm_on;
    logic [DUTY_W-1:0] duty;
    logic relay1_req;
    logic relay2_req;
    logic relay2_keep;
    logic hs_drive;

    assign awake_nxt = (state_nxt == S_ACTIVE) | (state_nxt == S_HOLD);
    assign duty = cfg_r[CFG_DUTY_LO +: DUTY_W];
    // Zero duty means steady on, so plain switching needs no duty write
    assign pwm_on = (duty == '0) | (pwm_cnt_r < duty);
    assign relay1_req = pins_s2_r.relay1_input | ctl_r[CTL_RELAY1];
    assign relay2_req = pins_s2_r.relay2_input | ctl_r[CTL_RELAY2];
    assign relay2_keep = outputs_on | ((state_r == S_HOLD) & cfg_r[CFG_SDD]);
    assign hs_drive = outputs_on & ctl_r[CTL_HSON] & pwm_on;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_cnt_r <= '0;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            host_reset_n_r <= 1'b0;
            pre_reg_en_r <= 1'b0;
            sensor_r <= 1'b0;
            relay1_r <= 1'b0;
            relay2_r <= 1'b0;
            key_state_r <= 1'b0;
        end else begin
            host_reset_n_r <= awake_nxt;
            pre_reg_en_r <= (state_nxt != S_SLEEP);
            sensor_r <= awake_nxt & ctl_nxt[CTL_SENSOR];
            relay1_r <= outputs_on & relay1_req;
            relay2_r <= relay2_keep & relay2_req;
            key_state_r <= cfg_r[CFG_HSD] ? hs_drive : key_in;
        end
    end

    assign host_reset_n = host_reset_n_r;
    assign pre_reg_en = pre_reg_en_r;
    // Both regulators follow the same sequencing; kept apart for the board
    assign vcc_reg_en = pre_reg_en_r;
    assign sensor_supply = sensor_r;
    assign relay1_driver = relay1_r;
    assign relay2_driver = relay2_r;
    assign key_state_out = key_state_r;
    assign status_word = snap_r;
endmodule
`default_nettype wire

// [testbench/sps_chk.sv]
// Port-level assertions for the serial power sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_chk
    import sps_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic chip_select_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n,
    input wire sps_pins_t pins,
    input wire logic host_reset_n,
    input wire logic pre_reg_en,
    input wire logic vcc_reg_en,
    input wire logic sensor_supply,
    input wire logic relay1_driver,
    input wire logic relay2_driver
);
    logic [TMR_W-1:0] por_cnt_r;
    logic [TMR_W-1:0] uv_cnt_r;
    logic [TMR_W-1:0] key_cnt_r;

    // Saturating run length, so long waits never wrap back below a bound
    function automatic logic [TMR_W-1:0] bump(input logic [TMR_W-1:0] c, input logic en);
        return !en ? '0 : (&c ? c : c + 1'b1);
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            por_cnt_r <= '0;
            uv_cnt_r <= '0;
            key_cnt_r <= '0;
        end else begin
            por_cnt_r <= bump(por_cnt_r, pins.vcc_por_ok);
            uv_cnt_r <= bump(uv_cnt_r, pins.vcc_uv_low);
            key_cnt_r <= bump(key_cnt_r, pins.key_switch_in);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    oe_tracks_select_a:
    assert property (spi_miso_oe_n == chip_select_n) else $error("miso enable off select");
    miso_on_fall_a:
    assert property (!chip_select_n && $past(!chip_select_n, 6) && $changed(spi_miso)
        |-> $fell(spi_sclk)) else $error("miso moved off a clock fall");
    por_delay_a:
    assert property ($rose(host_reset_n) |-> por_cnt_r >= POR_CYC) else $error("reset too short");
    uv_forces_reset_a:
    assert property (uv_cnt_r > UV_CYC + 12'd6 |-> !host_reset_n) else $error("uv missed");
    wake_regulator_a:
    assert property (key_cnt_r > 12'd6 |-> pre_reg_en && vcc_reg_en) else $error("no wake");
    relay_pin_or_a:
    assert property (host_reset_n && key_cnt_r > 12'd6 && $past(pins.relay2_input, 4)
        && pins.relay2_input |-> relay2_driver) else $error("relay 2 pin ignored");
    key_off_outputs_a:
    assert property (!pins.key_switch_in && $past(!pins.key_switch_in, 6) |-> !relay1_driver)
        else $error("relay 1 on with key off");
    reset_clears_a:
    assert property (!host_reset_n && $past(!host_reset_n, 3) |-> !sensor_supply)
        else $error("sensor supply on in reset");
endmodule
bind sps_top sps_chk u_chk (.clk, .resetn, .spi_sclk, .chip_select_n, .spi_miso,
    .spi_miso_oe_n, .pins, .host_reset_n, .pre_reg_en, .vcc_reg_en, .sensor_supply,
    .relay1_driver, .relay2_driver);
`default_nettype wire

// [testbench/sps_host_model.sv]
// Host serial master model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // One frame of n pulses; odd offset keeps the serial clock off the core clock edges
    task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        #1.3;
        cs_n = 1'b0;
        mosi = cmd[15];
        #120;
        for (int i = 0; i < n; i++) begin
            if (!miso_oe_n) rx = {rx[14:0], miso};
            sclk = 1'b1;
            #80;
            sclk = 1'b0;
            mosi = cmd[(14 - i) & 15];
            #80;
        end
        cs_n = 1'b1;
        mosi = ~mosi;
        #1200;
    endtask

    // Clock and data wiggle with select high, as a misbehaving bus would
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            mosi = ~mosi;
            #80;
            sclk = 1'b0;
            #80;
        end
    endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the serial power sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sps_pkg::*;
;
    logic clk, resetn, sclk, cs_n, mosi, miso, miso_oe_n, key_state_out;
    logic host_reset_n, pre_reg_en, vcc_reg_en, sensor_supply, relay1_driver, relay2_driver;
    logic [WORD_W-1:0] status_word, rx;
    sps_pins_t pins;
    int mismatches, n_checks;

    sps_host_model host (.sclk, .cs_n, .mosi, .miso, .miso_oe_n);
    sps_top dut (.clk, .resetn, .spi_sclk(sclk), .chip_select_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .pins, .host_reset_n, .pre_reg_en,
        .vcc_reg_en, .sensor_supply, .relay1_driver, .relay2_driver, .key_state_out,
        .status_word);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_rst(input int lim);
        for (int i = 0; i < lim && host_reset_n !== 1'b1; i++) @(posedge clk);
        if (host_reset_n !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t host reset never released", $time);
            test_done();
        end
    endtask

    task automatic send(input logic [3:0] a, input logic [11:0] d);
        host.xfer({a, d}, 16, rx);
    endtask

    task automatic t_power_up();
        @(posedge clk);
        pins.key_switch_in <= 1'b1;
        pins.vcc_por_ok <= 1'b1;
        cyc(10);
        chk(pre_reg_en, 1'b1, "pre-regulator off after wake");
        cyc(2400);
        chk(host_reset_n, 1'b0, "host reset released early");
        wait_rst(200);
        chk(sensor_supply, 1'b0, "sensor supply on after reset");
    endtask

    task automatic t_ctrl_status();
        send(ADDR_CTL, 12'h007);
        chk(sensor_supply, 1'b1, "sensor supply not on");
        chk(relay1_driver, 1'b1, "relay 1 command not applied");
        chk(key_state_out, 1'b1, "key state not following key");
        @(posedge clk);
        pins.fault <= 4'h5;
        cyc(10);
        host.xfer(16'h0000, 16, rx);
        chk(rx, 16'h6805, "status word");
        chk(status_word, 16'h6805, "status snapshot");
        @(posedge clk);
        pins.fault <= 4'h0;
    endtask

    task automatic t_errors();
        logic [15:0] cmd [4] = '{16'h1000, 16'h1000, 16'h1000, 16'h7007};
        int npl [4] = '{15, 17, 0, 16};
        for (int i = 0; i < 4; i++) begin
            host.xfer(cmd[i], npl[i], rx);
            host.xfer(16'h0000, 16, rx);
            chk(rx, 16'hE800, "error bit not set");
            chk(sensor_supply, 1'b1, "bad frame applied");
        end
        host.idle_clocks(8);
        chk(miso_oe_n, 1'b1, "output driven while deselected");
        host.xfer(16'h0000, 16, rx);
        chk(rx, 16'h6800, "clocks counted while deselected");
    endtask

    task automatic t_relay_or();
        @(posedge clk);
        pins.relay2_input <= 1'b1;
        cyc(10);
        chk(relay2_driver, 1'b1, "relay 2 pin ignored");
        pins.relay2_input <= 1'b0;
        cyc(10);
        chk(relay2_driver, 1'b0, "relay 2 stuck on");
    endtask

    task automatic t_hsd();
        int ones = 0;
        send(ADDR_CFG, 12'h001);
        send(ADDR_CTL, 12'h013);
        chk(key_state_out, 1'b1, "high-side driver not on");
        send(ADDR_CFG, 12'h101);
        @(posedge clk);
        for (int i = 0; i < 128; i++) begin
            @(posedge clk);
            if (key_state_out === 1'b1) ones++;
        end
        chk(16'(ones), 16'h0040, "high-side duty wrong");
        send(ADDR_CTL, 12'h003);
        chk(key_state_out, 1'b0, "high-side driver not off");
        send(ADDR_CFG, 12'h000);
        chk(key_state_out, 1'b1, "key state mode not restored");
    endtask

    task automatic t_uv();
        @(posedge clk);
        pins.vcc_uv_low <= 1'b1;
        cyc(300);
        pins.vcc_uv_low <= 1'b0;
        cyc(10);
        chk(host_reset_n, 1'b1, "short dip caused reset");
        pins.vcc_uv_low <= 1'b1;
        cyc(520);
        chk(host_reset_n, 1'b0, "undervoltage not caught");
        host.xfer(16'h0000, 16, rx);
        chk(rx, 16'h7000, "undervoltage status wrong");
        @(posedge clk);
        pins.vcc_uv_low <= 1'b0;
        wait_rst(2700);
        chk(sensor_supply, 1'b0, "control kept over reset");
    endtask

    task automatic t_hold();
        send(ADDR_CFG, 12'h002);
        send(ADDR_CTL, 12'h00F);
        @(posedge clk);
        pins.key_switch_in <= 1'b0;
        cyc(20);
        chk(relay1_driver, 1'b0, "relay 1 kept on in hold");
        chk(relay2_driver, 1'b1, "relay 2 dropped despite defeat");
        chk(key_state_out, 1'b0, "key state output stuck");
        chk(pre_reg_en, 1'b1, "supply dropped while held");
        send(ADDR_CTL, 12'h008);
        chk(pre_reg_en, 1'b0, "no sleep with hold cleared");
        chk(relay2_driver, 1'b0, "relay 2 on in sleep");
        @(posedge clk);
        pins.key_switch_in <= 1'b1;
        cyc(20);
        chk(host_reset_n, 1'b0, "no reset on wake");
        wait_rst(2700);
        chk(sensor_supply, 1'b0, "control kept over wake");
        @(posedge clk);
        pins.key_switch_in <= 1'b0;
        cyc(20);
        chk(pre_reg_en, 1'b0, "no sleep with key off, hold clear");
    endtask

    initial begin
        resetn = 1'b0;
        pins = PINS_RST;
        mismatches = 0;
        n_checks = 0;
        cyc(2);
        resetn <= 1'b1;
        t_power_up();
        t_ctrl_status();
        t_errors();
        t_relay_or();
        t_hsd();
        t_uv();
        t_hold();
        test_done();
    end
endmodule
`default_nettype wire
